// ---- bench/psc_host_model.sv ----
`timescale 1ns/1ps
// Host that drives the request line and clocks the bitstream in
module psc_host_model #(
   parameter int REQ_LOW_CYC = 250,
   parameter int CF2CK_CYC = 62500,
   parameter int ST2CK_CYC = 250
) (
   input wire logic sys_clk_i,
   input wire logic status_w_i,
   output logic request_n_o,
   output logic sclk_o,
   output logic sdata_o
);
   int since_req = 0;
   initial begin
      request_n_o = 1'b1;
      sclk_o = 1'b0;
      sdata_o = 1'b0;
   end
   // Age of the last request release, for the clock start gap
   always @(posedge sys_clk_i) begin
      since_req <= request_n_o ? since_req + 1 : 0;
   end
   task automatic pulse_request();
      @(posedge sys_clk_i);
      #1 request_n_o = 1'b0;
      repeat (REQ_LOW_CYC) @(posedge sys_clk_i);
      #1 request_n_o = 1'b1;
   endtask
   // Bounded wait: status high and request gap served, then the status gap
   task automatic wait_ready(output logic ok);
      for (int i = 0; i < CF2CK_CYC + 4000 && !(status_w_i === 1'b1 && since_req >= CF2CK_CYC); i++) begin
         @(posedge sys_clk_i);
      end
      ok = (status_w_i === 1'b1) && (since_req >= CF2CK_CYC);
      repeat (ST2CK_CYC) @(posedge sys_clk_i);
   endtask
   // One link period; the clock is parked low between frames
   task automatic tick();
      #3 sclk_o = 1'b1;
      #3 sclk_o = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         sdata_o = b[i];
         tick();
      end
      // Released data no longer shows the last bit
      sdata_o = ~sdata_o;
   endtask
   task automatic falls(input int n);
      repeat (n) tick();
   endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import psc_pkg::*;
   localparam int STARTS = 10;
   localparam int UCLK_CYC = 6;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic ext_status_low = 1'b0;
   logic ext_done_low = 1'b0;
   logic uclk = 1'b0;
   logic sel = 1'b0;
   logic req_n, sclk, sdata, status_oe, done_oe, user_mode, byte_valid;
   logic status_drv, done_drv;
   logic [7:0] cfg_byte;
   logic [7:0] got[$];
   int mismatches = 0;
   int total_checks = 0;
   // Shared open-drain wires with pull-ups
   wire logic status_w = (status_oe ? status_drv : 1'b1) & ~ext_status_low;
   wire logic done_w = (done_oe ? done_drv : 1'b1) & ~ext_done_low;
   initial forever #4 sys_clk = ~sys_clk;
   always #24 uclk = ~uclk;
   always @(posedge sys_clk) if (byte_valid === 1'b1) got.push_back(cfg_byte);
   psc_slave #(.CFG_BITS(32), .START_CLKS(STARTS)) psc_slave_i (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .clk_en_i(clk_en), .config_request_n_i(req_n),
      .status_n_i(status_w), .status_n_o(status_drv), .status_oe_o(status_oe), .done_i(done_w),
      .done_o(done_drv),
      .done_oe_o(done_oe), .config_serial_clock_i(sclk), .config_serial_data_i(sdata),
      .user_startup_clock_i(uclk), .startup_clk_sel_i(sel), .user_mode_o(user_mode),
      .cfg_byte_o(cfg_byte), .cfg_byte_valid_o(byte_valid));
   // Request-to-clock gap shortened to keep the run brief
   psc_host_model #(.CF2CK_CYC(1500)) psc_host_model_i (
      .sys_clk_i(sys_clk), .status_w_i(status_w), .request_n_o(req_n), .sclk_o(sclk), .sdata_o(sdata));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   function automatic logic sig(input int k);
      case (k)
         0: return status_oe;
         1: return done_oe;
         default: return user_mode;
      endcase
   endfunction
   // Bounded wait; running out counts as a mismatch and ends the run
   task automatic wait_for(input int k, input logic v, input int lim, output int n);
      for (n = 0; sig(k) !== v; n++) begin
         if (n == lim) begin
            check("wait bound", 0, 1);
            summarize();
         end
         cyc(1);
      end
   endtask
   // Host readiness; a host that never saw the line free ends the run
   task automatic host_ready();
      logic ok;
      psc_host_model_i.wait_ready(ok);
      check("host ready", ok, 1);
      if (ok !== 1'b1) summarize();
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic por_hold();
      int n;
      check("status_oe por", status_oe, 1);
      check("done_oe por", done_oe, 1);
      check("status drive level", status_drv, 0);
      check("done drive level", done_drv, 0);
      wait_for(0, 1'b0, POR_DELAY_CYC + 8, n);
      check("por length", n + 4 >= POR_DELAY_CYC, 1);
      check("done_oe after por", done_oe, 1);
   endtask
   // Load with completion held by a neighbour, then start-up
   task automatic load_frame(input logic s);
      int n;
      logic [7:0] tx[4] = '{8'ha5, 8'h01, 8'hfe, 8'h3c};
      sel = s;
      ext_done_low = 1'b1;
      got.delete();
      host_ready();
      #1;
      for (int i = 0; i < 4; i++) begin
         if (i == 3) check("done_oe in load", done_oe, 1);
         psc_host_model_i.send_byte(tx[i]);
      end
      wait_for(1, 1'b0, 20, n);
      // The last byte is strobed with the completion release; let it be collected
      cyc(1);
      check("byte count", got.size(), 4);
      for (int i = 0; i < 4; i++) check("cfg byte", got[i], tx[i]);
      psc_host_model_i.falls(2);
      cyc(60);
      check("user_mode done held", user_mode, 0);
      ext_done_low = 1'b0;
      cyc(5);
      psc_host_model_i.falls(1);
      cyc(60);
      check("user_mode one fall", user_mode, 0);
      psc_host_model_i.falls(1);
      wait_for(2, 1'b1, s ? STARTS * UCLK_CYC + 40 : INIT_MIN_CYC + 20, n);
      if (s) check("user clock start", n + 2 * UCLK_CYC >= STARTS * UCLK_CYC, 1);
      else check("oscillator start", n + 4 >= INIT_MIN_CYC, 1);
   endtask
   task automatic reconfig();
      int n;
      fork
         psc_host_model_i.pulse_request();
         begin
            @(negedge req_n);
            wait_for(1, 1'b1, CF2CD_MAX_CYC, n);
            wait_for(0, 1'b1, CF2CD_MAX_CYC, n);
            check("user_mode dropped", user_mode, 0);
         end
      join
      wait_for(0, 1'b0, STATUS_MAX_US * 1000000 / CLK_PERIOD_PS, n);
      check("status pulse min", n + 250 >= STATUS_MIN_CYC, 1);
   endtask
   // A neighbour pulls status low mid-load: nothing more is taken
   task automatic chain_error();
      psc_host_model_i.pulse_request();
      got.delete();
      host_ready();
      #1;
      psc_host_model_i.send_byte(8'h5a);
      cyc(10);
      ext_status_low = 1'b1;
      cyc(20);
      ext_status_low = 1'b0;
      for (int i = 0; i < 3; i++) psc_host_model_i.send_byte(8'hc3);
      psc_host_model_i.falls(2);
      cyc(100);
      check("bytes after halt", got.size(), 1);
      check("done_oe after halt", done_oe, 1);
      check("user_mode after halt", user_mode, 0);
   endtask
   // Frozen system side lets the ring overrun
   task automatic overrun();
      int n;
      psc_host_model_i.pulse_request();
      host_ready();
      #1;
      clk_en = 1'b0;
      for (int i = 0; i < 3; i++) psc_host_model_i.send_byte(8'h96);
      cyc(1);
      clk_en = 1'b1;
      wait_for(0, 1'b1, 20, n);
      wait_for(0, 1'b0, STATUS_MIN_CYC + 50, n);
      check("error pulse", n + 20 >= STATUS_MIN_CYC, 1);
      check("done_oe after error", done_oe, 1);
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      cyc(1);
      por_hold();
      load_frame(1'b0);
      reconfig();
      load_frame(1'b1);
      chain_error();
      psc_host_model_i.pulse_request();
      load_frame(1'b0);
      overrun();
      summarize();
   end
endmodule

// ---- hdl/psc_pkg.sv ----
// Notes on behaviour
// R1 - Request low aborts user mode, reconfigures
// R2 - Completion low within 800 ns
// R3 - Status low within 800 ns
// R4 - Host holds request low 2 us
// R5 - Status low pulse 10 to 500 us
// R6 - Status released within 500 us
// R7 - Host waits 500 us before clocking
// R8 - Host waits 2 us after status
// R9 - Status low through power-on delay
// R10 - Completion low until transfer ends
// R11 - Host clocks bits until completion
// R12 - Two falling clock edges start initialization
// R13 - Host parks serial clock steady
// R14 - Oscillator start-up 55 to 150 us
// R15 - User clock start-up, 4 periods, 8532
// R16 - Joined completion: all start together
// R17 - Joined status: any error halts chain
// R18 - Data sampled on serial clock rise
// R19 - Host sends each byte LSB first
// R20 - Error pulls status line low
// R21 - Host restarts after status low
package psc_pkg;

   // ---------------------------------------------
   // Timing, all but the two start-up edge counts derived from the system clock
   // ---------------------------------------------
   localparam int CLK_PERIOD_PS = 8000;
   localparam int CF2CD_MAX_NS = 800;
   localparam int STATUS_MIN_US = 10;
   localparam int STATUS_MAX_US = 500;
   localparam int POR_DELAY_US = 100;
   localparam int INIT_MIN_US = 55;
   localparam int INIT_MAX_US = 150;
   localparam int CONFIG_SERIAL_CLOCK_MAX_PERIOD_NS = 8;
   localparam int CU_DELAY_PERIODS = 4;
   localparam int STARTUP_CLKS = 8532;
   localparam int CF2CD_MAX_CYC = (CF2CD_MAX_NS * 1000) / CLK_PERIOD_PS;
   localparam int STATUS_MIN_CYC = (STATUS_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int POR_DELAY_CYC = (POR_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int INIT_MIN_CYC = (INIT_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CU_DELAY_CYC =
      (CU_DELAY_PERIODS * CONFIG_SERIAL_CLOCK_MAX_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int START_FALLS = 2;

   // ---------------------------------------------
   // Structure
   // ---------------------------------------------
   localparam int CNT_W = 24;
   localparam int PTR_W = 5;
   localparam int RING_DEPTH = 16;
   localparam int CFG_BITS_DFLT = 256;

   typedef enum logic [3:0] {
      ST_POR, ST_RESET, ST_WAIT, ST_LOAD, ST_ERROR,
      ST_HALT, ST_DONE, ST_INIT, ST_CUDLY, ST_CUCNT, ST_USER
   } psc_state_e;

   // Lines that arrive from the board
   typedef struct packed {
      logic req_n;
      logic status_n;
      logic done;
      logic uclk;
   } psc_line_s;

endpackage

// ---- hdl/psc_slave.sv ----
`timescale 1ns/1ps
module psc_slave
   import psc_pkg::*;
#(
   parameter int CFG_BITS = CFG_BITS_DFLT,
   parameter int POR_CYC = POR_DELAY_CYC,
   parameter int INIT_CYC = INIT_MIN_CYC,
   parameter int START_CLKS = STARTUP_CLKS
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic config_request_n_i,
   input wire logic status_n_i,
   output logic status_n_o,
   output logic status_oe_o,
   input wire logic done_i,
   output logic done_o,
   output logic done_oe_o,
   input wire logic config_serial_clock_i,
   input wire logic config_serial_data_i,
   input wire logic user_startup_clock_i,
   input wire logic startup_clk_sel_i,
   output logic user_mode_o,
   output logic [7:0] cfg_byte_o,
   output logic cfg_byte_valid_o
);

   // ---------------------------------------------
   // Gray helpers
   // ---------------------------------------------
   function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
      logic [PTR_W-1:0] b;
      b = '0;
      b[PTR_W-1] = g[PTR_W-1];
      for (int i = PTR_W - 2; i >= 0; i--) begin
         b[i] = g[i] ^ b[i+1];
      end
      return b;
   endfunction

   // ---------------------------------------------
   // Link domain: serial clock side
   // ---------------------------------------------
   // No reset edge exists here, so start values come from declarations;
   // the pointer is only used relative to a base caught at load start
   logic [PTR_W-1:0] wbin_reg = '0;
   logic [PTR_W-1:0] wgray_reg = '0;
   logic [RING_DEPTH-1:0] ring_reg = '0;
   logic fall_tgl_reg = 1'b0;

   // One bit per rising edge into the ring
   always_ff @(posedge config_serial_clock_i) begin
      ring_reg[wbin_reg[3:0]] <= config_serial_data_i; // R18
      wbin_reg <= wbin_reg + 1'b1;
      wgray_reg <= bin2gray(wbin_reg + 1'b1);
   end

   // Falling edges reported as a toggle
   always_ff @(negedge config_serial_clock_i) begin
      fall_tgl_reg <= ~fall_tgl_reg;
   end

   chk_link_sample: assert property (@(posedge config_serial_clock_i) // R18
      ##1 wbin_reg == $past(wbin_reg) + 1'b1)
      else $error("serial bit not taken on rising edge");

   // ---------------------------------------------
   // Synchronisers into the system domain
   // ---------------------------------------------
   psc_line_s sync1_reg;
   psc_line_s line_reg;
   logic uclk_d_reg;
   logic [PTR_W-1:0] wg1_reg;
   logic [PTR_W-1:0] wg2_reg;
   logic [2:0] ftg_reg;

   // Two flops before anything but the clock select looks at a pin
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         sync1_reg <= '{req_n: 1'b1, status_n: 1'b1, done: 1'b0, uclk: 1'b0};
         line_reg <= '{req_n: 1'b1, status_n: 1'b1, done: 1'b0, uclk: 1'b0};
         uclk_d_reg <= 1'b0;
         wg1_reg <= '0;
         wg2_reg <= '0;
         ftg_reg <= '0;
      end else if (clk_en_i) begin
         sync1_reg <= '{req_n: config_request_n_i, status_n: status_n_i,
                        done: done_i, uclk: user_startup_clock_i};
         line_reg <= sync1_reg;
         uclk_d_reg <= line_reg.uclk;
         wg1_reg <= wgray_reg;
         wg2_reg <= wg1_reg;
         ftg_reg <= {ftg_reg[1:0], fall_tgl_reg};
      end
   end

   logic uclk_rise;
   logic fall_seen;
   logic [PTR_W-1:0] wbin_s;

   assign uclk_rise = line_reg.uclk & ~uclk_d_reg;
   assign fall_seen = ftg_reg[2] ^ ftg_reg[1];
   assign wbin_s = gray2bin(wg2_reg);

   // ---------------------------------------------
   // Sequencer
   // ---------------------------------------------
   psc_state_e state_reg;
   psc_state_e state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [PTR_W-1:0] rbin_reg;
   logic [PTR_W-1:0] fill;
   logic [31:0] bits_reg;
   logic [1:0] falls_reg;
   logic avail;
   logic overrun;
   logic last_bit;

   assign fill = wbin_s - rbin_reg;
   assign avail = (fill != '0);
   // More than a ring's worth ahead means bits were overwritten
   assign overrun = (fill > PTR_W'(RING_DEPTH));
   assign last_bit = avail && (bits_reg == 32'(CFG_BITS - 1));

   // Next state; a low request outranks everything but power-on
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_POR: begin
            if (cnt_reg >= CNT_W'(POR_CYC - 1)) begin // R9
               state_next = line_reg.req_n ? ST_WAIT : ST_RESET;
            end
         end
         ST_RESET: begin
            if (line_reg.req_n && cnt_reg >= CNT_W'(STATUS_MIN_CYC - 1)) begin // R5
               state_next = ST_WAIT; // R6
            end
         end
         ST_WAIT: begin
            // Another device or the board may stretch the low time
            if (line_reg.status_n) begin
               state_next = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (overrun) begin
               state_next = ST_ERROR; // R20
            end else if (!line_reg.status_n) begin
               state_next = ST_HALT; // R17
            end else if (last_bit) begin
               state_next = ST_DONE; // R10
            end
         end
         ST_ERROR: begin
            if (cnt_reg >= CNT_W'(STATUS_MIN_CYC - 1)) begin
               state_next = ST_HALT;
            end
         end
         ST_HALT: begin
            state_next = ST_HALT;
         end
         ST_DONE: begin
            // Joined completion line: wait until every device let go
            if (line_reg.done && falls_reg == 2'(START_FALLS)) begin // R16 R12
               state_next = startup_clk_sel_i ? ST_CUDLY : ST_INIT;
            end
         end
         ST_INIT: begin
            if (cnt_reg >= CNT_W'(INIT_CYC - 1)) begin // R14
               state_next = ST_USER;
            end
         end
         ST_CUDLY: begin
            if (cnt_reg >= CNT_W'(CU_DELAY_CYC - 1)) begin // R15
               state_next = ST_CUCNT;
            end
         end
         ST_CUCNT: begin
            if (uclk_rise && cnt_reg >= CNT_W'(START_CLKS - 1)) begin // R15
               state_next = ST_USER;
            end
         end
         ST_USER: begin
            state_next = ST_USER;
         end
         default: begin
            state_next = ST_POR;
         end
      endcase
      if (!line_reg.req_n && state_reg != ST_POR) begin
         state_next = ST_RESET; // R1
      end
   end

   // State register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_POR;
      end else if (clk_en_i) begin
         state_reg <= state_next;
      end
   end

   // Phase timer, restarts on every state change
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         cnt_reg <= '0;
      end else if (clk_en_i) begin
         if (state_next != state_reg) begin
            cnt_reg <= '0;
         end else if (state_reg != ST_CUCNT || uclk_rise) begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   // Falling edges counted only once completion is high
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         falls_reg <= '0;
      end else if (clk_en_i) begin
         if (state_reg != ST_DONE || !line_reg.done) begin
            falls_reg <= '0;
         end else if (fall_seen && falls_reg != 2'(START_FALLS)) begin
            falls_reg <= falls_reg + 1'b1; // R12
         end
      end
   end

   // ---------------------------------------------
   // Bit stream assembly
   // ---------------------------------------------
   logic [7:0] shift_reg;
   logic [2:0] nbit_reg;

   // Bits clocked before load are stale, so the base is caught on entry
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rbin_reg <= '0;
         bits_reg <= '0;
         shift_reg <= '0;
         nbit_reg <= '0;
      end else if (clk_en_i) begin
         if (state_reg != ST_LOAD) begin
            rbin_reg <= wbin_s;
            bits_reg <= '0;
            nbit_reg <= '0;
         end else if (avail && !overrun) begin
            rbin_reg <= rbin_reg + 1'b1;
            bits_reg <= bits_reg + 1'b1;
            shift_reg <= {ring_reg[rbin_reg[3:0]], shift_reg[7:1]}; // R19
            nbit_reg <= nbit_reg + 1'b1;
         end
      end
   end

   // A byte is handed out once its eighth bit is in, never in a cycle that halts the load
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         cfg_byte_o <= '0;
         cfg_byte_valid_o <= 1'b0;
      end else if (clk_en_i) begin
         cfg_byte_valid_o <= 1'b0;
         if (state_reg == ST_LOAD && (state_next == ST_LOAD || state_next == ST_DONE)
             && avail && !overrun && nbit_reg == 3'h7) begin // R17
            cfg_byte_o <= {ring_reg[rbin_reg[3:0]], shift_reg[7:1]};
            cfg_byte_valid_o <= 1'b1;
         end
      end
   end

   // ---------------------------------------------
   // Open-drain lines and mode
   // ---------------------------------------------
   // Lines are only ever pulled low; release is left to the pull-up
   assign status_n_o = 1'b0;
   assign done_o = 1'b0;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         status_oe_o <= 1'b1;
         done_oe_o <= 1'b1;
         user_mode_o <= 1'b0;
      end else if (clk_en_i) begin
         status_oe_o <= (state_next == ST_POR) || (state_next == ST_RESET)
                        || (state_next == ST_ERROR); // R3 R9 R20
         done_oe_o <= (state_next == ST_POR) || (state_next == ST_RESET)
                      || (state_next == ST_WAIT) || (state_next == ST_LOAD)
                      || (state_next == ST_ERROR) || (state_next == ST_HALT); // R2 R10
         user_mode_o <= (state_next == ST_USER);
      end
   end

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   chk_req_abort: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R1
      clk_en_i && !line_reg.req_n && state_reg == ST_USER |=> state_reg == ST_RESET && !user_mode_o)
      else $error("user mode kept after request low");

   chk_done_fall: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R2
      clk_en_i && !line_reg.req_n && state_reg != ST_POR |=> done_oe_o)
      else $error("completion not pulled low after request");

   chk_status_fall: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R3
      clk_en_i && !line_reg.req_n && state_reg != ST_POR |=> status_oe_o)
      else $error("status not pulled low after request");

   chk_pulse_min: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R5
      $past(state_reg) == ST_RESET && state_reg == ST_WAIT
      |-> $past(cnt_reg) >= CNT_W'(STATUS_MIN_CYC - 1))
      else $error("status pulse shorter than minimum");

   chk_status_release: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R6
      clk_en_i && state_reg == ST_RESET && line_reg.req_n
      && cnt_reg >= CNT_W'(STATUS_MIN_CYC - 1) |=> !status_oe_o)
      else $error("status not released after request high");

   chk_por_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R9
      state_reg == ST_POR |-> status_oe_o && done_oe_o)
      else $error("status released during power-on delay");

   chk_done_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R10
      state_reg inside {ST_WAIT, ST_LOAD} |-> done_oe_o && !user_mode_o)
      else $error("completion released before transfer end");

   chk_two_falls: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R12
      $past(state_reg) == ST_DONE && state_reg inside {ST_INIT, ST_CUDLY}
      |-> $past(falls_reg) == 2'(START_FALLS))
      else $error("initialization before two falling edges");

   chk_osc_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R14
      $past(state_reg) == ST_INIT && state_reg == ST_USER
      |-> $past(cnt_reg) == CNT_W'(INIT_CYC - 1))
      else $error("oscillator start-up time wrong");

   chk_user_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R15
      $past(state_reg) == ST_CUCNT && state_reg == ST_USER
      |-> $past(cnt_reg) == CNT_W'(START_CLKS - 1))
      else $error("user clock start-up count wrong");

   chk_chain_sync: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R16
      $past(state_reg) == ST_DONE && state_reg != ST_DONE && state_reg != ST_RESET
      |-> $past(line_reg.done))
      else $error("start-up while completion line low");

   chk_chain_halt: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R17
      clk_en_i && line_reg.req_n && state_reg == ST_LOAD && !overrun
      && !line_reg.status_n |=> state_reg == ST_HALT && cfg_byte_valid_o == 1'b0)
      else $error("load continued after chain error");

   chk_error_pull: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R20
      state_reg == ST_ERROR |-> status_oe_o)
      else $error("error without status pulled low");

endmodule
